/* hw/ppc_pkg.sv */
// package for the channel power and reset command block
// assumes one four-channel group per instance, registers reached by byte write port
package ppc_pkg;
  localparam logic [7:0] PPC_OFS_POWER_CMD = 8'h19;         // channel_power_command
  localparam logic [7:0] PPC_OFS_RESET_CMD = 8'h1A;         // reset_command
  localparam logic [7:0] PPC_CMD_RESET_VAL = 8'h00;         // trigger bytes reset value
  localparam int         PPC_OFF_LSB       = 4;             // power-off triggers 7..4
  localparam int         PPC_ON_LSB        = 0;             // power-on triggers 3..0
  localparam int         PPC_CLR_ALL_BIT   = 7;             // clear_all_interrupts
  localparam int         PPC_IRQ_REL_BIT   = 6;             // release_irq_pin_only
  localparam int         PPC_SOFT_RST_BIT  = 4;             // global_soft_reset
  localparam int         PPC_FORCE_LSB     = 0;             // chan_force_off 3..0
  localparam logic [7:0] PPC_POLICE_OFF    = 8'hFF;         // policing byte after turn-off
  localparam int         PPC_CLK_HZ        = 20_000_000;    // clk_sys rate
  localparam int         PPC_CLEAR_MS      = 5;             // longest clear time
  localparam int         PPC_CLEAR_CYC     = PPC_CLK_HZ / 1000 * PPC_CLEAR_MS;
  // operating modes of the group
  typedef enum logic [3:0] {
    PPC_MODE_OFF    = 4'b0001,
    PPC_MODE_MANUAL = 4'b0010,
    PPC_MODE_SEMI   = 4'b0100,
    PPC_MODE_AUTO   = 4'b1000
  } ppc_mode_e;
  // per-channel status supplied by the analog/sequencer side
  typedef struct packed {
    logic cooldown;   // overload, current limit or inrush cool-down running
    logic disconnect; // disconnect event this cycle
    logic det_en;     // discovery_enable_bit
    logic cls_en;     // class_enable_bit
    logic cls_start;  // classification has started in current cycle
    logic cls_done;   // classification finished this cycle
    logic cls_valid;  // detection and class result valid
    logic pwr_ok;     // allocated power suffices
  } ppc_chan_s;
endpackage

/* hw/ppc_chan.sv */
// one channel: turn-on arming and power state
// assumes triggers are single-cycle pulses from the command decoder
`timescale 1ns/1ps
`default_nettype none
module ppc_chan
  import ppc_pkg::*;
(
  input  wire logic      clk_sys,
  input  wire logic      rst,
  input  wire ppc_mode_e mode,
  input  wire ppc_chan_s st,
  input  wire logic      on_trig,   // power-on trigger pulse
  input  wire logic      off_trig,  // power-off or force-off pulse
  output logic           powered,
  output logic           det_kick   // request one detect/class cycle
);
  logic armed;   // one attempt pending
  logic both_en;
  assign both_en = st.det_en & st.cls_en;

  // arm on a trigger; an attempt is spent on any class completion
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      armed <= 1'b0;
    end else if (off_trig || st.cooldown || st.disconnect) begin
      armed <= 1'b0;
    end else if (on_trig && (mode == PPC_MODE_SEMI || mode == PPC_MODE_AUTO)) begin
      armed <= 1'b1;
    end else if (st.cls_done) begin
      armed <= 1'b0;
    end
  end

  // one full cycle is started when enables do not already cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      det_kick <= 1'b0;
    end else begin
      det_kick <= on_trig & ~off_trig & ~st.cooldown & ~both_en &
                  (mode == PPC_MODE_SEMI || mode == PPC_MODE_AUTO);
    end
  end

  // power state; off and faults win over any turn-on
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      powered <= 1'b0;
    end else if (off_trig || st.cooldown || st.disconnect || mode == PPC_MODE_OFF) begin
      powered <= 1'b0;
    end else if (on_trig && mode == PPC_MODE_MANUAL) begin
      powered <= 1'b1;
    end else if (st.cls_done && st.cls_valid && st.pwr_ok &&
                 (armed || (mode == PPC_MODE_AUTO && both_en))) begin
      powered <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* hw/ppc_cmd.sv */
// channel power and reset command registers for one group of four channels
// assumes a byte write/read port from the management link decoder, one clock
// Operation
// RULE1 - power command at 19h except off mode
// RULE2 - bits 7-4 off, 3-0 on triggers
// RULE3 - on and off together means off
// RULE4 - faults and cool-down beat turn-on
// RULE5 - manual mode turns channel on immediately
// RULE6 - semi-auto makes one attempt, no retry
// RULE7 - semi-auto lacking enables runs full cycle
// RULE8 - semi-auto both enables uses next cycle
// RULE9 - early trigger powers right after classification
// RULE10 - auto lacking enables runs one cycle
// RULE11 - auto both enables powers without trigger
// RULE12 - host sets power allocation first
// RULE13 - power-off clears channel state, policing FFh
// RULE14 - clearing touches only channels turned off
// RULE15 - clearing may take up to 5ms
// RULE16 - reset register at 1Ah self-clearing triggers
// RULE17 - bit7 clears events, interrupts, releases pin
// RULE18 - bit6 releases pin only
// RULE19 - bit4 soft reset, supply flags keep tracking
// RULE20 - soft reset preserves listed registers
// RULE21 - soft reset affects only this group
// RULE22 - bits 3-0 force channels off
// RULE23 - force-off clears same, aborts cool-down
// RULE24 - no pin reassert until pending cleared
// RULE25 - host waits 3ms after force-off
// RULE26 - command registers read as zero
// RULE27 - reset bit 5 does nothing
`timescale 1ns/1ps
`default_nettype none
module ppc_cmd
  import ppc_pkg::*;
(
  input  wire logic            clk_sys,
  input  wire logic            rst,
  input  wire logic            wr_en,        // byte write strobe
  input  wire logic            rd_en,        // byte read strobe
  input  wire logic [7:0]      addr,         // command code
  input  wire logic [7:0]      wdata,
  input  wire ppc_mode_e       mode,         // group operating mode
  input  wire ppc_chan_s [3:0] chan_st,      // per-channel status
  input  wire logic            irq_pending,  // any interrupt bit still set
  input  wire logic            irq_event,    // a new interrupt event
  output logic [7:0]           rdata,
  output logic [3:0]           chan_on,      // channel powered
  output logic [3:0]           det_kick,     // start one detect/class cycle
  output logic [3:0]           chan_clear,   // clear channel state, held while clearing
  output logic [3:0]           cooldown_abort,
  output logic [7:0]           police_load,  // value for cleared policing bytes
  output logic                 clr_events,   // clear events and interrupt register
  output logic                 soft_reset,   // restore non-preserved registers
  output logic                 irq_out       // interrupt pin, high when asserted
);
  import ppc_pkg::*;

  localparam logic [22:0] CLR_LAST = 23'(PPC_CLEAR_CYC - 1);

  logic       wr_pwr;             // write to power command
  logic       wr_rst;             // write to reset command
  logic [3:0] on_raw;
  logic [3:0] off_raw;
  logic [3:0] force_raw;
  logic [3:0] next_on;
  logic [3:0] next_off;
  logic [3:0] on_trig;            // registered pulses into channels
  logic [3:0] off_trig;
  logic [3:0] powered;
  logic [3:0] kick;
  logic [22:0] clr_cnt;           // clear window counter
  logic       irq_hold;           // pin held released until pending clears

  // decode writes; off mode ignores the power command entirely
  assign wr_pwr    = wr_en && addr == PPC_OFS_POWER_CMD && mode != PPC_MODE_OFF; // [RULE1]
  assign wr_rst    = wr_en && addr == PPC_OFS_RESET_CMD;                        // [RULE16]
  assign off_raw   = wr_pwr ? wdata[PPC_OFF_LSB +: 4] : 4'h0;                   // [RULE2]
  assign on_raw    = wr_pwr ? wdata[PPC_ON_LSB +: 4] : 4'h0;                    // [RULE2]
  assign force_raw = wr_rst ? wdata[PPC_FORCE_LSB +: 4] : 4'h0;                 // [RULE22]

  // off beats on in the same write; force-off shares the off path
  always_comb begin
    next_off = off_raw | force_raw;                     // [RULE23]
    next_on  = on_raw & ~next_off;                      // [RULE3]
  end

  // trigger pulses, one cycle wide; no state is held in the command bytes
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      on_trig  <= 4'h0;
      off_trig <= 4'h0;
    end else begin
      on_trig  <= next_on;
      off_trig <= next_off;
    end
  end

  // force-off aborts cool-down of just the named channels
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cooldown_abort <= 4'h0;
    end else begin
      cooldown_abort <= force_raw;                      // [RULE23]
    end
  end

  // per-channel power control
  for (genvar i = 0; i < 4; i++) begin : g_chan
    ppc_chan u_chan (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .mode     (mode),
      .st       (chan_st[i]),
      .on_trig  (on_trig[i]),   // [RULE4] [RULE5] [RULE6] [RULE9] [RULE10] [RULE11]
      .off_trig (off_trig[i]),  // [RULE13]
      .powered  (powered[i]),
      .det_kick (kick[i])       // [RULE7] [RULE8]
    );
  end

  // outputs from flops
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      chan_on  <= 4'h0;
      det_kick <= 4'h0;
    end else begin
      chan_on  <= powered;
      det_kick <= kick;
    end
  end

  // clear window: only channels turned off, held until the window ends;
  // the window is bounded so downstream clearing finishes within it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      chan_clear <= 4'h0;
      clr_cnt    <= '0;
    end else if (|next_off) begin
      chan_clear <= chan_clear | next_off;              // [RULE14]
      clr_cnt    <= CLR_LAST;                           // [RULE15]
    end else if (clr_cnt != '0) begin
      clr_cnt    <= clr_cnt - 23'd1;
    end else begin
      chan_clear <= 4'h0;
    end
  end

  // policing value loaded into cleared channels
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      police_load <= PPC_POLICE_OFF;
    end else begin
      police_load <= PPC_POLICE_OFF;                    // [RULE13]
    end
  end

  // global actions of the reset register; bit 5 is not decoded
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      clr_events <= 1'b0;
      soft_reset <= 1'b0;
    end else begin
      clr_events <= wr_rst & wdata[PPC_CLR_ALL_BIT];    // [RULE17] [RULE27]
      // only this group's copy; preserved registers and live supply
      // flags are the register file's concern, not gated here
      soft_reset <= wr_rst & wdata[PPC_SOFT_RST_BIT];   // [RULE19] [RULE20] [RULE21]
    end
  end

  // interrupt pin; after a bit 6 release it stays low until nothing is pending
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_hold <= 1'b0;
      irq_out  <= 1'b0;
    end else if (wr_rst && (wdata[PPC_CLR_ALL_BIT] || wdata[PPC_IRQ_REL_BIT])) begin
      irq_hold <= ~wdata[PPC_CLR_ALL_BIT];              // [RULE18]
      irq_out  <= 1'b0;                                 // [RULE17]
    end else if (irq_hold) begin
      irq_hold <= irq_pending;                          // [RULE24]
      irq_out  <= 1'b0;
    end else begin
      irq_out  <= irq_pending | irq_event;
    end
  end

  // both command registers read back zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata <= PPC_CMD_RESET_VAL;
    end else if (rd_en) begin
      rdata <= PPC_CMD_RESET_VAL;                       // [RULE26]
    end
  end

  // checks
  property p_off_wins;
    @(posedge clk_sys) disable iff (rst)
      (wr_pwr && wdata[5] && wdata[1]) |-> ##1 !on_trig[1] ##1 !powered[1];
  endproperty
  a_off_wins: assert property (p_off_wins) else $error("on won over off"); // [RULE3]

  property p_off_mode;
    @(posedge clk_sys) disable iff (rst)
      (wr_en && addr == PPC_OFS_POWER_CMD && mode == PPC_MODE_OFF) |-> ##1 on_trig == 4'h0;
  endproperty
  a_off_mode: assert property (p_off_mode) else $error("trigger in off mode"); // [RULE1]

  property p_manual_on;
    @(posedge clk_sys) disable iff (rst)
      (wr_pwr && mode == PPC_MODE_MANUAL && wdata[0] && !wdata[4]
       && !chan_st[0].cooldown && !chan_st[0].disconnect)
      ##1 (mode == PPC_MODE_MANUAL && !chan_st[0].cooldown && !chan_st[0].disconnect)
      |-> ##1 powered[0] ##1 chan_on[0];
  endproperty
  a_manual_on: assert property (p_manual_on) else $error("manual on late"); // [RULE5]

  property p_cooldown;
    @(posedge clk_sys) disable iff (rst)
      chan_st[1].cooldown |=> !powered[1];
  endproperty
  a_cooldown: assert property (p_cooldown) else $error("powered in cooldown"); // [RULE4]

  property p_off_clear;
    @(posedge clk_sys) disable iff (rst)
      (wr_pwr && wdata[5]) |=> chan_clear[1] && clr_cnt == CLR_LAST;
  endproperty
  a_off_clear: assert property (p_off_clear) else $error("clear missing"); // [RULE13]

  property p_only_named;
    @(posedge clk_sys) disable iff (rst)
      (|next_off) |=> ((chan_clear ^ $past(chan_clear)) & ~$past(next_off)) == 4'h0
                      && (chan_clear & $past(next_off)) == $past(next_off);
  endproperty
  a_only_named: assert property (p_only_named) else $error("wrong channel cleared"); // [RULE14]

  property p_release;
    @(posedge clk_sys) disable iff (rst)
      (wr_rst && wdata[PPC_IRQ_REL_BIT]) |=> !irq_out && !clr_events;
  endproperty
  a_release: assert property (p_release) else $error("pin not released"); // [RULE18]

  property p_hold;
    @(posedge clk_sys) disable iff (rst)
      (irq_hold && irq_pending) |=> !irq_out;
  endproperty
  a_hold: assert property (p_hold) else $error("pin reasserted early"); // [RULE24]

  property p_clr_all;
    @(posedge clk_sys) disable iff (rst)
      (wr_rst && wdata[PPC_CLR_ALL_BIT]) |=> clr_events && !irq_out ##1 !clr_events;
  endproperty
  a_clr_all: assert property (p_clr_all) else $error("clear all wrong"); // [RULE17]

  property p_force_abort;
    @(posedge clk_sys) disable iff (rst)
      (wr_rst && wdata[1]) |=> cooldown_abort[1] && off_trig[1];
  endproperty
  a_force_abort: assert property (p_force_abort) else $error("force-off incomplete"); // [RULE23]

  property p_read_zero;
    @(posedge clk_sys) disable iff (rst)
      rd_en |=> rdata == 8'h00;
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("read not zero"); // [RULE26]

  c_manual: cover property (@(posedge clk_sys) disable iff (rst) on_trig[0] ##1 powered[0]);
  c_force: cover property (@(posedge clk_sys) disable iff (rst) cooldown_abort != 4'h0);
  c_soft: cover property (@(posedge clk_sys) disable iff (rst) soft_reset);
endmodule
`default_nettype wire

/* dv/ppc_host.sv */
// host model: byte writes and reads on the command port
// assumes clk_sys from the bench and one call at a time
`timescale 1ns/1ps
`default_nettype none
module ppc_host (
  input  wire logic       clk_sys,
  input  wire logic [7:0] rdata,
  output logic            wr_en,
  output logic            rd_en,
  output logic [7:0]      addr,
  output logic [7:0]      wdata
);
  localparam int HOLD_CYC = 60000;  // 3 ms at 50 ns
  int unsigned   cyc = 0;           // free-running cycle count
  int unsigned   forced[4];         // cycle of last force-off
  logic [3:0]    held = 4'h0;       // channel forced off at least once
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
  end
  always @(posedge clk_sys) cyc <= cyc + 1;
  // power allocation (pwr_ok) is settled before any trigger
  // cleared values are never read back inside the clear window
  task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
    for (int n = 0; n < 4; n++) begin
      // no turn-on of a forced-off channel within 3 ms
      while (a == 8'h19 && d[n] && held[n] && cyc - forced[n] < HOLD_CYC) @(posedge clk_sys);
    end
    @(posedge clk_sys);
    #1;
    wr_en = 1'b1;
    addr = a;
    wdata = d;
    @(posedge clk_sys);
    #1;
    wr_en = 1'b0;
    addr = ~a;   // stale bus shows the inverse
    wdata = ~d;
    for (int n = 0; n < 4; n++) begin
      if (a == 8'h1A && d[n]) begin
        held[n] = 1'b1;
        forced[n] = cyc;
      end
    end
  endtask
  // read strobe for one cycle, data taken one cycle later
  task automatic read_byte(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    #1;
    rd_en = 1'b1;
    addr = a;
    @(posedge clk_sys);
    #1;
    rd_en = 1'b0;
    @(posedge clk_sys);
    #1;
    d = rdata;
  endtask
endmodule
`default_nettype wire

/* dv/test_pse_port_power_reset_cmds.sv */
// bench for the channel power and reset command block
// assumes the host model drives the byte port, bench drives status lines
`timescale 1ns/1ps
`default_nettype none
module test_pse_port_power_reset_cmds;
  import ppc_pkg::*;
  typedef struct packed {
    logic [7:0]  addr;
    ppc_mode_e   mode;
    logic [7:0]  wdata;
    logic [3:0]  on;    // expected chan_on
    logic [13:0] ev;    // expected {chan_clear, seen}
    logic [13:0] mask;  // which of ev are compared
  } ppc_row_s;
  // ordinary cases, state carries from row to row
  localparam ppc_row_s ROWS[9] = '{
    '{8'h19, PPC_MODE_MANUAL, 8'h0F, 4'hF, 14'h0000, 14'h3FFF},
    '{8'h19, PPC_MODE_MANUAL, 8'h22, 4'hD, 14'h0800, 14'h3F0F},
    '{8'h19, PPC_MODE_MANUAL, 8'h50, 4'h8, 14'h1C00, 14'h3F0F},
    '{8'h19, PPC_MODE_OFF,    8'h01, 4'h0, 14'h0000, 14'h0000},
    '{8'h19, PPC_MODE_MANUAL, 8'h00, 4'h0, 14'h0000, 14'h030F},
    '{8'h19, PPC_MODE_MANUAL, 8'h0F, 4'hF, 14'h0000, 14'h030F},
    '{8'h1A, PPC_MODE_MANUAL, 8'h0A, 4'h5, 14'h3CA0, 14'h3FFF},
    '{8'h1A, PPC_MODE_MANUAL, 8'h20, 4'h5, 14'h0000, 14'h03FF},
    '{8'h1A, PPC_MODE_MANUAL, 8'h80, 4'h5, 14'h0200, 14'h03FF}};
  logic            clk_sys;
  logic            rst;
  logic            wr_en;
  logic            rd_en;
  logic [7:0]      addr;
  logic [7:0]      wdata;
  ppc_mode_e       mode;
  ppc_chan_s [3:0] chan_st;
  logic            irq_pending;
  logic            irq_event;
  logic [7:0]      rdata;
  logic [3:0]      chan_on;
  logic [3:0]      det_kick;
  logic [3:0]      chan_clear;
  logic [3:0]      cooldown_abort;
  logic [7:0]      police_load;
  logic            clr_events;
  logic            soft_reset;
  logic            irq_out;
  logic [9:0]      seen;          // sticky pulses since last clear
  logic            seen_clr;
  int              num_errors = 0;
  int              checks = 0;
  ppc_host host (.clk_sys(clk_sys), .rdata(rdata), .wr_en(wr_en), .rd_en(rd_en),
                 .addr(addr), .wdata(wdata));
  ppc_cmd DUT (.clk_sys(clk_sys), .rst(rst), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
               .wdata(wdata), .mode(mode), .chan_st(chan_st), .irq_pending(irq_pending),
               .irq_event(irq_event), .rdata(rdata), .chan_on(chan_on), .det_kick(det_kick),
               .chan_clear(chan_clear), .cooldown_abort(cooldown_abort),
               .police_load(police_load), .clr_events(clr_events),
               .soft_reset(soft_reset), .irq_out(irq_out));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // one-cycle pulses are caught here so a late check still sees them
  always @(posedge clk_sys) begin
    if (seen_clr) seen <= '0;
    else seen <= seen | {clr_events, soft_reset, cooldown_abort, det_kick};
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("errors=%0d checks=%0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // write, then let the answer and any pulses land
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    seen_clr = 1'b1;
    host.write_byte(a, d);
    seen_clr = 1'b0;
    repeat (6) @(posedge clk_sys);
    #1;
  endtask
  // one classification result on a channel
  task automatic cls(input int ch, input logic ok);
    chan_st[ch].cls_valid = ok;
    chan_st[ch].cls_done = 1'b1;
    @(posedge clk_sys);
    #1;
    chan_st[ch].cls_done = 1'b0;
    repeat (5) @(posedge clk_sys);
    #1;
  endtask
  task automatic irq_pulse;
    irq_event = 1'b1;
    @(posedge clk_sys);
    #1;
    irq_event = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  initial begin
    repeat (90000) @(posedge clk_sys);
    num_errors++;
    stop_test();
  end
  initial begin
    logic [7:0] rd;
    rst = 1'b1;
    mode = PPC_MODE_MANUAL;
    chan_st = '0;
    for (int n = 0; n < 4; n++) chan_st[n].pwr_ok = 1'b1;
    irq_pending = 1'b0;
    irq_event = 1'b0;
    seen_clr = 1'b1;
    repeat (10) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    foreach (ROWS[i]) begin
      mode = ROWS[i].mode;
      wr(ROWS[i].addr, ROWS[i].wdata);
      check(16'(chan_on), 16'(ROWS[i].on));
      check(16'({chan_clear, seen} & ROWS[i].mask), 16'(ROWS[i].ev));
      host.read_byte(ROWS[i].addr, rd);
      check(16'(rd), 16'h0000);
    end
    // turn-on refused during cool-down; host first waits out the hold-off
    chan_st[1].cooldown = 1'b1;
    wr(8'h19, 8'h02);
    check(16'(chan_on), 16'h0005);
    chan_st[1].cooldown = 1'b0;
    // semi-auto: both enables give one attempt, no retry without a new trigger; lacking enables kicks a cycle
    mode = PPC_MODE_SEMI;
    chan_st[3].det_en = 1'b1;
    chan_st[3].cls_en = 1'b1;
    wr(8'h19, 8'h08);
    cls(3, 1'b0);
    cls(3, 1'b1);
    check(16'(chan_on), 16'h0005);
    wr(8'h19, 8'h08);
    cls(3, 1'b1);
    check(16'(chan_on), 16'h000D);
    wr(8'h19, 8'h02);
    check(16'(seen), 16'h0002);
    cls(1, 1'b1);
    check(16'(chan_on), 16'h000F);
    // auto mode: trigger kicks a cycle, both enables power unasked
    mode = PPC_MODE_AUTO;
    wr(8'h19, 8'hA0);
    check(16'(chan_on), 16'h0005);
    wr(8'h19, 8'h02);
    check(16'(seen), 16'h0002);
    cls(1, 1'b1);
    cls(3, 1'b1);
    check(16'(chan_on), 16'h000F);
    // interrupt pin: release holds it low until nothing is pending
    irq_pending = 1'b1;
    irq_pulse();
    check(16'(irq_out), 16'h0001);
    wr(8'h1A, 8'h40);
    check(16'(irq_out), 16'h0000);
    irq_pulse();
    check(16'(irq_out), 16'h0000);
    irq_pending = 1'b0;
    @(posedge clk_sys);
    #1;
    irq_pending = 1'b1;
    irq_pulse();
    check(16'(irq_out), 16'h0001);
    seen_clr = 1'b1;
    host.write_byte(8'h1A, 8'h80);
    seen_clr = 1'b0;
    check(16'(irq_out), 16'h0000);
    // the register file drops pending once all events are cleared
    irq_pending = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    check(16'({irq_out, seen[9]}), 16'h0001);
    wr(8'h1A, 8'h10);
    check(16'(seen[8]), 16'h0001);
    // second reset in mid-run
    rst = 1'b1;
    #1;
    check(16'({chan_on, police_load}), 16'h00FF);
    check(16'(rdata), 16'h0000);
    @(posedge clk_sys);
    #1;
    rst = 1'b0;
    // the block must take a command straight after the release
    mode = PPC_MODE_MANUAL;
    wr(8'h19, 8'h01);
    check(16'(chan_on), 16'h0001);
    stop_test();
  end
endmodule
`default_nettype wire
